// *** rtl/fhc_host.sv ***
// host controller driving a strobe-clocked 16k x 9 fifo through its pins
// assumes flag and data pins are synchronous to aclk; software on axi4-lite
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
// How it works
// - host clears device before any write
// - strobes high around clear rising edge
// - offset loaded by strobe during clear
// - strobes held high during replay
// - replay only within depth since reset
module fhc_host #(
  parameter int DATA_W = fhc_pkg::DATA_W,
  parameter int DEPTH = fhc_pkg::DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output fhc_pkg::fhc_pins_s pins,
  input wire logic [DATA_W-1:0] dq_i,
  input wire logic empty_flag_n,
  input wire logic full_flag_n,
  input wire logic half_level_flag_n
);
  // refused at elaboration, not at run time
  if (DATA_W != fhc_pkg::DATA_W || DEPTH != fhc_pkg::DEPTH) begin : g_bad_geometry
    $error("fhc_host: width and depth must match the pin struct");
  end
  if (fhc_pkg::STROBE_CYC > 255 || fhc_pkg::SETUP_CYC > 255 || fhc_pkg::HOLD_CYC > 255) begin : g_bad_timing
    $error("fhc_host: timing counts exceed counter");
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic known(input logic [7:0] a);
    return a == fhc_pkg::OFF_CMD || a == fhc_pkg::OFF_WDATA || a == fhc_pkg::OFF_RDATA ||
           a == fhc_pkg::OFF_STATUS || a == fhc_pkg::OFF_WCOUNT ||
           a == fhc_pkg::OFF_OFFSET || a == fhc_pkg::OFF_THRESH;
  endfunction

  localparam logic [7:0] STROBE_N = 8'(fhc_pkg::STROBE_CYC - 1);
  localparam logic [7:0] SETUP_N = 8'(fhc_pkg::SETUP_CYC - 1);
  localparam logic [7:0] HOLD_N = 8'(fhc_pkg::HOLD_CYC - 1);
  localparam logic [14:0] WCNT_MAX = 15'(DEPTH + 1);

  // fsm state, read by the bus side
  fhc_pkg::fhc_st_e st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  fhc_pkg::fhc_pins_s pins_q, pins_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic ready_q, ready_d;
  logic refused_q, refused_d;
  logic loaded_q, loaded_d;
  logic [14:0] wcnt_q, wcnt_d;
  logic [2:0] ldmode_q, ldmode_d;

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rd_q, rd_d;
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wbuf_q, wbuf_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic go_q, go_d, clr_q, clr_d;
  logic [2:0] code_q, code_d;
  logic [DATA_W-1:0] word_q, word_d, ofs_q, ofs_d;
  logic [31:0] thresh;
  logic [31:0] status;

  always_comb begin
    // default threshold until an offset load is seen
    thresh = loaded_q ? 32'(ofs_q) * fhc_pkg::OFS_UNIT : fhc_pkg::OFS_DEFAULT;
    status = 32'h0;
    status[fhc_pkg::ST_BUSY] = st_q != fhc_pkg::S_IDLE;
    status[fhc_pkg::ST_READY] = ready_q;
    status[fhc_pkg::ST_EMPTY_N] = empty_flag_n;
    status[fhc_pkg::ST_FULL_N] = full_flag_n;
    status[fhc_pkg::ST_HALF_N] = half_level_flag_n;
    status[fhc_pkg::ST_REFUSED] = refused_q;
    status[fhc_pkg::ST_LOADED] = loaded_q;
  end

  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wbuf_d = wbuf_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rd_d = rd_q;
    go_d = 1'b0;
    clr_d = 1'b0;
    code_d = code_q;
    word_d = word_q;
    ofs_d = ofs_q;
    if (s_awvalid && awready_q) begin
      aw_held_d = 1'b1;
      awaddr_d = s_awaddr;
    end
    if (s_wvalid && wready_q) begin
      w_held_d = 1'b1;
      wbuf_d = s_wdata;
      wstrb_d = s_wstrb;
    end
    if (bvalid_q && s_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_held_q && w_held_q && !bvalid_q) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = known(awaddr_q) ? fhc_pkg::RESP_OKAY : fhc_pkg::RESP_SLVERR;
      if (awaddr_q == fhc_pkg::OFF_CMD) begin
        if (wstrb_q[0]) begin
          go_d = 1'b1;
          code_d = wbuf_q[2:0];
        end
      end else if (awaddr_q == fhc_pkg::OFF_WDATA) begin
        word_d = DATA_W'(merge(32'(word_q), wbuf_q, wstrb_q));
      end else if (awaddr_q == fhc_pkg::OFF_OFFSET) begin
        ofs_d = DATA_W'(merge(32'(ofs_q), wbuf_q, wstrb_q));
      end else if (awaddr_q == fhc_pkg::OFF_STATUS) begin
        clr_d = wstrb_q[0] && wbuf_q[fhc_pkg::ST_REFUSED];
      end
    end
    if (rvalid_q && s_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = known(s_araddr) ? fhc_pkg::RESP_OKAY : fhc_pkg::RESP_SLVERR;
      if (s_araddr == fhc_pkg::OFF_WDATA) begin
        rd_d = 32'(word_q);
      end else if (s_araddr == fhc_pkg::OFF_RDATA) begin
        rd_d = 32'(rdata_q);
      end else if (s_araddr == fhc_pkg::OFF_STATUS) begin
        rd_d = status;
      end else if (s_araddr == fhc_pkg::OFF_WCOUNT) begin
        rd_d = 32'(wcnt_q);
      end else if (s_araddr == fhc_pkg::OFF_OFFSET) begin
        rd_d = 32'(ofs_q);
      end else if (s_araddr == fhc_pkg::OFF_THRESH) begin
        rd_d = thresh;
      end else begin
        rd_d = 32'h0;
      end
    end
    // one write and one read in flight; ready drops until the answer is taken
    awready_d = !aw_held_d && !bvalid_d;
    wready_d = !w_held_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wbuf_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rd_q <= 32'h0;
      go_q <= 1'b0;
      clr_q <= 1'b0;
      code_q <= 3'h0;
      word_q <= '0;
      ofs_q <= '0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wbuf_q <= wbuf_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rd_q <= rd_d;
      go_q <= go_d;
      clr_q <= clr_d;
      code_q <= code_d;
      word_q <= word_d;
      ofs_q <= ofs_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
    end
  end

  // ****************************************
  // pin sequencer
  // ****************************************
  always_comb begin
    logic refuse;
    refuse = 1'b0;
    st_d = st_q;
    cnt_d = (cnt_q != 8'h00) ? cnt_q - 8'h01 : 8'h00;
    pins_d = pins_q;
    pins_d.chain_in_n = 1'b0;
    rdata_d = rdata_q;
    ready_d = ready_q;
    loaded_d = loaded_q;
    wcnt_d = wcnt_q;
    ldmode_d = ldmode_q;
    case (st_q)
      fhc_pkg::S_IDLE: begin
        if (go_q) begin
          case (code_q)
            fhc_pkg::CMD_RESET, fhc_pkg::CMD_RESET_PUSH, fhc_pkg::CMD_RESET_POP: begin
              pins_d.clear_pulse_n = 1'b0;
              ldmode_d = code_q;
              ready_d = 1'b0;
              loaded_d = 1'b0;
              wcnt_d = 15'h0;
              st_d = fhc_pkg::S_RS_SET;
              cnt_d = SETUP_N;
            end
            fhc_pkg::CMD_WRITE: begin
              // writes are refused until a clear has been done
              if (!ready_q || !full_flag_n) begin
                refuse = 1'b1;
              end else begin
                pins_d.data_in = word_q;
                pins_d.push_n = 1'b0;
                wcnt_d = (wcnt_q < WCNT_MAX) ? wcnt_q + 15'h1 : wcnt_q;
                st_d = fhc_pkg::S_WR_LOW;
                cnt_d = STROBE_N;
              end
            end
            fhc_pkg::CMD_READ: begin
              if (!ready_q || !empty_flag_n) begin
                refuse = 1'b1;
              end else begin
                pins_d.pop_n = 1'b0;
                st_d = fhc_pkg::S_RD_LOW;
                cnt_d = STROBE_N;
              end
            end
            fhc_pkg::CMD_REPLAY: begin
              // beyond one depth of writes the old words are overwritten
              if (!ready_q || wcnt_q > 15'(DEPTH)) begin
                refuse = 1'b1;
              end else begin
                pins_d.replay_pulse_n = 1'b0;
                st_d = fhc_pkg::S_RT_LOW;
                cnt_d = STROBE_N;
              end
            end
            default: refuse = 1'b1;
          endcase
        end
      end
      fhc_pkg::S_RS_SET: begin
        if (cnt_q == 8'h00) begin
          cnt_d = STROBE_N;
          if (ldmode_q == fhc_pkg::CMD_RESET_PUSH) begin
            pins_d.data_in = ofs_q;
            pins_d.push_n = 1'b0;
            st_d = fhc_pkg::S_LD_LOW;
          end else if (ldmode_q == fhc_pkg::CMD_RESET_POP) begin
            pins_d.dq_o = ofs_q;
            pins_d.dq_oe = 1'b1;
            pins_d.pop_n = 1'b0;
            st_d = fhc_pkg::S_LD_LOW;
          end else begin
            pins_d.clear_pulse_n = 1'b1;
            st_d = fhc_pkg::S_RS_REL;
            cnt_d = HOLD_N;
          end
        end
      end
      fhc_pkg::S_LD_LOW: begin
        if (cnt_q == 8'h00) begin
          pins_d.push_n = 1'b1;
          pins_d.pop_n = 1'b1;
          loaded_d = 1'b1;
          st_d = fhc_pkg::S_LD_HIGH;
          cnt_d = SETUP_N;
        end
      end
      fhc_pkg::S_LD_HIGH: begin
        if (cnt_q == 8'h00) begin
          pins_d.dq_oe = 1'b0;
          pins_d.clear_pulse_n = 1'b1;
          st_d = fhc_pkg::S_RS_REL;
          cnt_d = HOLD_N;
        end
      end
      fhc_pkg::S_RS_REL: begin
        if (cnt_q == 8'h00) begin
          ready_d = 1'b1;
          st_d = fhc_pkg::S_IDLE;
        end
      end
      fhc_pkg::S_WR_LOW: begin
        if (cnt_q == 8'h00) begin
          pins_d.push_n = 1'b1;
          st_d = fhc_pkg::S_WR_HIGH;
          cnt_d = STROBE_N;
        end
      end
      fhc_pkg::S_RD_LOW: begin
        if (cnt_q == 8'h00) begin
          // outputs are only valid while pop is low
          rdata_d = dq_i;
          pins_d.pop_n = 1'b1;
          st_d = fhc_pkg::S_RD_HIGH;
          cnt_d = STROBE_N;
        end
      end
      fhc_pkg::S_RT_LOW: begin
        if (cnt_q == 8'h00) begin
          pins_d.replay_pulse_n = 1'b1;
          st_d = fhc_pkg::S_RT_HIGH;
          cnt_d = STROBE_N;
        end
      end
      fhc_pkg::S_WR_HIGH, fhc_pkg::S_RD_HIGH, fhc_pkg::S_RT_HIGH: begin
        if (cnt_q == 8'h00) begin
          st_d = fhc_pkg::S_IDLE;
        end
      end
      default: st_d = fhc_pkg::S_IDLE;
    endcase
    if (go_q && st_q != fhc_pkg::S_IDLE) begin
      refuse = 1'b1;
    end
    // a refusal in the clearing cycle stays visible
    refused_d = refuse || (refused_q && !clr_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= fhc_pkg::S_IDLE;
      cnt_q <= 8'h00;
      pins_q <= '{clear_pulse_n: 1'b1, push_n: 1'b1, pop_n: 1'b1, replay_pulse_n: 1'b1,
                  chain_in_n: 1'b0, data_in: '0, dq_o: '0, dq_oe: 1'b0};
      rdata_q <= '0;
      ready_q <= 1'b0;
      refused_q <= 1'b0;
      loaded_q <= 1'b0;
      wcnt_q <= 15'h0;
      ldmode_q <= 3'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      pins_q <= pins_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      refused_q <= refused_d;
      loaded_q <= loaded_d;
      wcnt_q <= wcnt_d;
      ldmode_q <= ldmode_d;
    end
  end

  assign pins = pins_q;
  assign s_awready = awready_q;
  assign s_wready = wready_q;
  assign s_bvalid = bvalid_q;
  assign s_bresp = bresp_q;
  assign s_arready = arready_q;
  assign s_rvalid = rvalid_q;
  assign s_rresp = rresp_q;
  assign s_rdata = rd_q;
endmodule // fhc_host

// *** rtl/fhc_pkg.sv ***
// constants, types and register map of the fifo host controller
// assumes one 10 MHz clock and an axi4-lite master with 32-bit data
package fhc_pkg;
  // ****************************************
  // fifo geometry
  // ****************************************
  localparam int DEPTH = 16384;
  localparam int DATA_W = 9;
  localparam int OFS_UNIT = 32;
  localparam int OFS_DEFAULT = 8192;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 10;
  localparam int STROBE_NS = 200;
  localparam int SETUP_NS = 100;
  localparam int HOLD_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_WDATA = 8'h04;
  localparam logic [7:0] OFF_RDATA = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_WCOUNT = 8'h10;
  localparam logic [7:0] OFF_OFFSET = 8'h14;
  localparam logic [7:0] OFF_THRESH = 8'h18;
  localparam int ST_BUSY = 0;
  localparam int ST_READY = 1;
  localparam int ST_EMPTY_N = 2;
  localparam int ST_FULL_N = 3;
  localparam int ST_HALF_N = 4;
  localparam int ST_REFUSED = 5;
  localparam int ST_LOADED = 6;
  localparam logic [2:0] CMD_RESET = 3'h1;
  localparam logic [2:0] CMD_RESET_PUSH = 3'h2;
  localparam logic [2:0] CMD_RESET_POP = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_REPLAY = 3'h6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic clear_pulse_n;
    logic push_n;
    logic pop_n;
    logic replay_pulse_n;
    logic chain_in_n;
    logic [DATA_W-1:0] data_in;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe;
  } fhc_pins_s;
  typedef enum logic [3:0] {
    S_IDLE, S_RS_SET, S_LD_LOW, S_LD_HIGH, S_RS_REL,
    S_WR_LOW, S_WR_HIGH, S_RD_LOW, S_RD_HIGH, S_RT_LOW, S_RT_HIGH
  } fhc_st_e;
endpackage

// *** tb/fhc_fifo_model.sv ***
// behavioural strobe-driven 9-bit fifo standing in for the device
// assumes single-device wiring; chained mode only switches the shared flag pin and blocks replay
`timescale 1ns/1ns
module fhc_fifo_model #(
  parameter int DEPTH = 64
) (
  input fhc_pkg::fhc_pins_s pins,
  output logic [8:0] dq_i,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic half_level_flag_n
);
  // ****************************************
  // pointers, offset and flags
  // ****************************************
  logic [8:0] mem [DEPTH];
  logic [8:0] out_q = 9'h000;
  logic [8:0] last_q = 9'h000;
  logic rd_q = 1'h0;
  logic half_q = 1'h1;
  int wp = 0;
  int rp = 0;
  int cnt = 0;
  int wr_n = 0;
  int thr = DEPTH / 2;
  // released bus shows inverse of last word, never a stale copy
  assign dq_i = pins.dq_oe ? pins.dq_o : (rd_q ? out_q : ~last_q);
  assign empty_flag_n = cnt != 0;
  assign full_flag_n = cnt != DEPTH;
  // shared pin: half flag when single, last-location pulse when chained
  assign half_level_flag_n = pins.chain_in_n ? (wp != DEPTH - 1) : half_q;
  always @(negedge pins.clear_pulse_n) begin
    wp = 0;
    rp = 0;
    cnt = 0;
    wr_n = 0;
    thr = DEPTH / 2;
    half_q = 1'h1;
  end
  always @(negedge pins.push_n) begin
    if (!pins.clear_pulse_n) thr = pins.data_in * 32;
    else if (cnt < DEPTH) begin
      mem[wp] = pins.data_in;
      wp = (wp + 1) % DEPTH;
      cnt++;
      wr_n++;
      if (cnt > thr) half_q = 1'h0;
    end
  end
  always @(negedge pins.pop_n) begin
    // read the pins directly: dq_i may not have settled in this time step
    if (!pins.clear_pulse_n) thr = (pins.dq_oe ? pins.dq_o : dq_i) * 32;
    else if (cnt > 0) begin
      out_q = mem[rp];
      rd_q = 1'h1;
      rp = (rp + 1) % DEPTH;
      cnt--;
    end
  end
  always @(posedge pins.pop_n) begin
    if (rd_q) last_q = out_q;
    rd_q = 1'h0;
    if (cnt <= thr) half_q = 1'h1;
  end
  always @(negedge pins.replay_pulse_n) begin
    if (!pins.chain_in_n) begin
      rp = 0;
      cnt = wr_n;
      half_q = !(cnt > thr);
    end
  end
endmodule // fhc_fifo_model

// *** tb/fhc_host_props.sv ***
// assertions on the host's fifo pin sequencing
// assumes binding into fhc_host; sees only its ports
`timescale 1ns/1ns
module fhc_host_props #(
  parameter int DEPTH = fhc_pkg::DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input fhc_pkg::fhc_pins_s pins,
  input wire logic empty_flag_n,
  input wire logic full_flag_n
);
  // ****************************************
  // helpers and properties
  // ****************************************
  logic seen_q = 1'h0;
  int wcnt_q = 0;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn) seen_q <= 1'h0;
    else if (!pins.clear_pulse_n) seen_q <= 1'h1;
    if (!pins.clear_pulse_n) wcnt_q <= 0;
    else if (!pins.push_n && $past(pins.push_n)) wcnt_q <= wcnt_q + 1;
  end
  property p_push_room;
    $fell(pins.push_n) && pins.clear_pulse_n |-> $past(full_flag_n);
  endproperty
  a_push_room: assert property (p_push_room) else $error("push while full");
  property p_pop_data;
    $fell(pins.pop_n) && pins.clear_pulse_n |-> $past(empty_flag_n);
  endproperty
  a_pop_data: assert property (p_pop_data) else $error("pop while empty");
  property p_clr_quiet;
    $rose(pins.clear_pulse_n) |-> $past(pins.push_n) && $past(pins.pop_n)
      ##0 (pins.push_n && pins.pop_n)[*2];
  endproperty
  a_clr_quiet: assert property (p_clr_quiet) else $error("strobe near clear rise");
  property p_rpl_quiet;
    !pins.replay_pulse_n |-> pins.push_n && pins.pop_n && pins.clear_pulse_n;
  endproperty
  a_rpl_quiet: assert property (p_rpl_quiet) else $error("strobe in replay");
  property p_clr_first;
    $fell(pins.push_n) |-> seen_q;
  endproperty
  a_clr_first: assert property (p_clr_first) else $error("push before clear");
  property p_pop_load;
    !pins.clear_pulse_n && !pins.pop_n |-> pins.dq_oe;
  endproperty
  a_pop_load: assert property (p_pop_load) else $error("offset bus undriven");
  property p_push_hold;
    $fell(pins.push_n) |=> !pins.push_n && $stable(pins.data_in) ##1 pins.push_n;
  endproperty
  a_push_hold: assert property (p_push_hold) else $error("push pulse malformed");
  property p_rpl_pulse;
    $fell(pins.replay_pulse_n) |-> wcnt_q <= DEPTH ##1 !pins.replay_pulse_n ##1 pins.replay_pulse_n;
  endproperty
  a_rpl_pulse: assert property (p_rpl_pulse) else $error("replay misuse");
  cover property (!pins.replay_pulse_n);
  cover property (!pins.clear_pulse_n && !pins.pop_n);
  cover property (!full_flag_n && pins.clear_pulse_n);
endmodule // fhc_host_props
bind fhc_host fhc_host_props #(.DEPTH(DEPTH)) u_fhc_host_props (.aclk(aclk), .aresetn(aresetn),
  .pins(pins), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n));

// *** tb/fhc_host_tb.sv ***
// self-checking bench: random fifo traffic through the host registers
// assumes the behavioural fifo model at a small depth for short runs
`timescale 1ns/1ns
module fhc_host_tb;
  // ****************************************
  // signals, tasks and sequence
  // ****************************************
  localparam int DEPTH = 64;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0, s_rdata, rd;
  logic [3:0] s_wstrb = 4'hF;
  logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, empty_flag_n, full_flag_n;
  logic half_level_flag_n;
  logic [1:0] s_bresp, s_rresp, rr, br;
  logic [8:0] dq_i;
  logic [8:0] q[$], hist[$];
  fhc_pkg::fhc_pins_s pins;
  int error_cnt = 0, checked = 0, thr = DEPTH / 2;
  always #50 aclk = ~aclk;
  fhc_host u_fhc_host (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .pins(pins), .dq_i(dq_i), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
    .half_level_flag_n(half_level_flag_n));
  fhc_fifo_model #(.DEPTH(DEPTH)) u_fhc_fifo_model (.pins(pins), .dq_i(dq_i),
    .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
    .half_level_flag_n(half_level_flag_n));
  function automatic logic [3:0] exp_flags(input int n);
    return {n <= thr, n != DEPTH, n != 0, 1'h1};
  endfunction
  task automatic give_verdict();
    $display("checked %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hang();
    error_cnt++;
    $display("ERROR bus wait expected answer seen none");
    give_verdict();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'h0;
      if (s_wready) s_wvalid <= 1'h0;
      if (s_bvalid) break;
    end
    if (n == 40) hang();
    br = s_bresp;
    s_bready <= 1'h0;
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'h0;
      if (s_rvalid) break;
    end
    if (n == 40) hang();
    rd = s_rdata;
    rr = s_rresp;
    s_rready <= 1'h0;
  endtask
  task automatic cmd(input logic [2:0] c);
    int n;
    wr(fhc_pkg::OFF_CMD, {29'h0, c});
    chk("bresp", br, fhc_pkg::RESP_OKAY);
    for (n = 0; n < 30; n++) begin
      rdr(fhc_pkg::OFF_STATUS);
      if (rd[fhc_pkg::ST_BUSY] === 1'h0) return;
    end
    hang();
  endtask
  task automatic rst(input logic [2:0] c, input logic [8:0] code);
    wr(fhc_pkg::OFF_OFFSET, {23'h0, code});
    cmd(c);
    q.delete();
    hist.delete();
    thr = (c == fhc_pkg::CMD_RESET) ? DEPTH / 2 : code * 32;
    rdr(fhc_pkg::OFF_THRESH);
    chk("thresh", rd, (c == fhc_pkg::CMD_RESET) ? 8192 : code * 32);
    rdr(fhc_pkg::OFF_OFFSET);
    chk("offset", rd, {23'h0, code});
    rdr(fhc_pkg::OFF_STATUS);
    chk("status", rd[6:1], {c != fhc_pkg::CMD_RESET, 1'h0, exp_flags(0)});
  endtask
  // full and empty attempts must be refused without touching the fifo
  task automatic op(input bit w, input logic [8:0] d);
    bit refuse;
    refuse = w ? q.size() == DEPTH : q.size() == 0;
    if (w) wr(fhc_pkg::OFF_WDATA, {23'h0, d});
    cmd(w ? fhc_pkg::CMD_WRITE : fhc_pkg::CMD_READ);
    if (!refuse && w) begin
      q.push_back(d);
      hist.push_back(d);
    end
    if (!refuse && !w) begin
      rdr(fhc_pkg::OFF_RDATA);
      chk("rdata", rd, {23'h0, q.pop_front()});
    end
    rdr(fhc_pkg::OFF_STATUS);
    chk("status", rd[5:1], {refuse, exp_flags(q.size())});
    if (refuse) wr(fhc_pkg::OFF_STATUS, 32'h20);
  endtask
  initial begin
    int i;
    i = $urandom(32'h65D8251C);
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rdr(fhc_pkg::OFF_STATUS);
    chk("ready", rd[1], 1'h0);
    cmd(fhc_pkg::CMD_WRITE);
    chk("early", rd[5], 1'h1);
    wr(fhc_pkg::OFF_STATUS, 32'h20);
    rst(fhc_pkg::CMD_RESET, 9'h000);
    op(1'h0, 9'h000);
    for (i = 0; i < 300; i++) op(($urandom % 10) < (i < 150 ? 8 : 2), 9'($urandom));
    rst(fhc_pkg::CMD_RESET_PUSH, 9'h001);
    for (i = 0; i < 5; i++) op(i < 3, 9'($urandom));
    cmd(fhc_pkg::CMD_REPLAY);
    q = hist;
    for (i = 0; i < 4; i++) op(1'h0, 9'h000);
    rdr(fhc_pkg::OFF_WCOUNT);
    chk("wcount", rd, hist.size());
    rst(fhc_pkg::CMD_RESET_PUSH, 9'h1FF);
    rst(fhc_pkg::CMD_RESET_POP, 9'h000);
    op(1'h1, 9'h0AA);
    op(1'h0, 9'h000);
    cmd(3'h7);
    chk("badcmd", rd[5], 1'h1);
    rdr(8'h1C);
    chk("rresp", rr, fhc_pkg::RESP_SLVERR);
    chk("rdata0", rd, 32'h0);
    wr(8'h1C, 32'h1);
    chk("bresp", br, fhc_pkg::RESP_SLVERR);
    give_verdict();
  end
endmodule // fhc_host_tb
